// ==== hw/srw_supervisor.sv ====
`timescale 1ns/1ps
`include "srw_regs.svh"
// Contract
// - Start condition restarts the watchdog count.
// - Enabled watchdog timeout asserts reset output.
// - Three timeout choices, kept across power.
// - Power-up holds reset 250ms after stable.
// - Supply below trip asserts reset.
// - Release after 200ms continuous good supply.
// - Open-drain reset, polarity fixed per variant.
// - No serial effect during power-on reset.
// - Lock pin plus protect bit blocks writes.
// - Select 00/01/10 timeouts, 11 disables.
// - Reset aborts transfers, nonvolatile write finishes.
module srw_supervisor
   import srw_pkg::*;
#(
   parameter bit ACTIVE_HIGH  = 1'b0,
   parameter int POR_HOLD_CYC = `SRW_POR_HOLD_CYC,
   parameter int LOW_HOLD_CYC = `SRW_LOW_HOLD_CYC,
   parameter int WD_SEL0_CYC  = `SRW_WD_SEL0_CYC,
   parameter int WD_SEL1_CYC  = `SRW_WD_SEL1_CYC,
   parameter int WD_SEL2_CYC  = `SRW_WD_SEL2_CYC,
   parameter int WD_HOLD_CYC  = `SRW_WD_HOLD_CYC
) (
   input  wire logic     clk_i,
   input  wire logic     reset_n_i,
   input  wire logic     supply_low_i,
   input  wire logic     scl_i,
   input  wire logic     sda_i,
   input  wire logic     write_lock_pin_i,
   input  wire logic     rst_pin_i,
   input  wire srw_cfg_s nv_cfg_i,
   input  wire logic     cfg_wr_valid_i,
   input  wire srw_cfg_s cfg_wr_data_i,
   output logic          rst_o,
   output logic          rst_oe_o,
   output logic          comm_enable_o,
   output logic          comm_abort_o,
   output logic          cfg_store_o,
   output srw_cfg_s      cfg_store_data_o,
   output logic          cfg_refused_o
);

   localparam int CW = `SRW_CNT_W;

   // Pins pass two flops; supply is taken as low until proven good.
   logic [3:0] pins_s;
   logic       low_s;
   logic       scl_s;
   logic       sda_s;
   logic       lock_s;
   srw_sync #(
      .WIDTH (4),
      .RST   (8'h0f)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({supply_low_i, scl_i, sda_i, write_lock_pin_i}),
      .sync_o    (pins_s)
   );
   assign low_s  = pins_s[3];
   assign scl_s  = pins_s[2];
   assign sda_s  = pins_s[1];
   assign lock_s = pins_s[0];

   // Start detection: data falls while clock stays high.
   logic scl_q;
   logic sda_q;
   logic start_seen;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end
   assign start_seen = scl_q & scl_s & sda_q & ~sda_s;

   // Supply supervision: power-on and low-supply holds share one counter.
   srw_sup_e        sup_q;
   srw_sup_e        sup_d;
   logic [CW-1:0]   sup_cnt_q;
   logic [CW-1:0]   sup_cnt_d;
   logic [CW-1:0]   sup_limit;
   always_comb begin
      sup_d     = sup_q;
      sup_cnt_d = sup_cnt_q;
      sup_limit = (sup_q == SUP_POR) ? CW'(POR_HOLD_CYC - 1) : CW'(LOW_HOLD_CYC - 1);
      unique case (sup_q)
         SUP_POR, SUP_LOW: begin
            if (low_s) begin
               sup_cnt_d = '0;
            end else if (sup_cnt_q >= sup_limit) begin
               sup_d     = SUP_RUN;
               sup_cnt_d = '0;
            end else begin
               sup_cnt_d = sup_cnt_q + CW'(1);
            end
         end
         SUP_RUN: begin
            if (low_s) begin
               sup_d     = SUP_LOW;
               sup_cnt_d = '0;
            end
         end
         default: begin
            sup_d     = SUP_POR;
            sup_cnt_d = '0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sup_q     <= SUP_POR;
         sup_cnt_q <= '0;
      end else begin
         sup_q     <= sup_d;
         sup_cnt_q <= sup_cnt_d;
      end
   end

   // Timeout choice comes straight from the nonvolatile cells, so a
   // power cycle cannot change it.
   logic [1:0]    sel;
   logic          wd_off;
   logic [CW-1:0] wd_limit;
   assign sel    = {nv_cfg_i.timeout_select_hi, nv_cfg_i.timeout_select_lo};
   assign wd_off = (sel == `SRW_SEL_DISABLED);
   always_comb begin
      unique case (sel)
         2'h0:    wd_limit = CW'(WD_SEL0_CYC - 1);
         2'h1:    wd_limit = CW'(WD_SEL1_CYC - 1);
         default: wd_limit = CW'(WD_SEL2_CYC - 1);
      endcase
   end

   // Watchdog: counts idle time, bites, then holds reset for a while.
   srw_wd_e       wd_q;
   srw_wd_e       wd_d;
   logic [CW-1:0] wd_cnt_q;
   logic [CW-1:0] wd_cnt_d;
   always_comb begin
      wd_d     = wd_q;
      wd_cnt_d = wd_cnt_q;
      unique case (wd_q)
         WD_RUN: begin
            if (start_seen || wd_off || sup_q != SUP_RUN) begin
               wd_cnt_d = '0;
            end else if (wd_cnt_q >= wd_limit) begin
               wd_d     = WD_BITE;
               wd_cnt_d = '0;
            end else begin
               wd_cnt_d = wd_cnt_q + CW'(1);
            end
         end
         WD_BITE: begin
            if (wd_cnt_q >= CW'(WD_HOLD_CYC - 1)) begin
               wd_d     = WD_RUN;
               wd_cnt_d = '0;
            end else begin
               wd_cnt_d = wd_cnt_q + CW'(1);
            end
         end
         default: begin
            wd_d     = WD_RUN;
            wd_cnt_d = '0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wd_q     <= WD_RUN;
         wd_cnt_q <= '0;
      end else begin
         wd_q     <= wd_d;
         wd_cnt_q <= wd_cnt_d;
      end
   end

   // Reset output and serial gating. The pin data is always low; only the
   // enable moves, so the wire is pulled or released as an open drain.
   logic     rst_q;
   logic     rst_d;
   logic     abort_q;
   logic     abort_d;
   logic     store_q;
   logic     store_d;
   logic     refused_q;
   logic     refused_d;
   logic     wr_ok;
   srw_cfg_s store_data_q;
   srw_cfg_s store_data_d;
   always_comb begin
      rst_d        = (sup_d != SUP_RUN) | (wd_d == WD_BITE);
      abort_d      = rst_d & ~rst_q & (sup_d != SUP_POR);
      wr_ok        = ~rst_q & ~(lock_s & nv_cfg_i.protect_enable_bit);
      store_d      = cfg_wr_valid_i & wr_ok;
      refused_d    = cfg_wr_valid_i & ~wr_ok;
      store_data_d = store_d ? cfg_wr_data_i : store_data_q;
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_q        <= 1'b1;
         abort_q      <= 1'b0;
         store_q      <= 1'b0;
         refused_q    <= 1'b0;
         store_data_q <= '0;
      end else begin
         rst_q        <= rst_d;
         abort_q      <= abort_d;
         store_q      <= store_d;
         refused_q    <= refused_d;
         store_data_q <= store_data_d;
      end
   end

   assign rst_o            = 1'b0;
   assign rst_oe_o         = rst_q ^ ACTIVE_HIGH;
   assign comm_enable_o    = ~rst_q;
   assign comm_abort_o     = abort_q;
   assign cfg_store_o      = store_q;
   assign cfg_store_data_o = store_data_q;
   assign cfg_refused_o    = refused_q;

   // Checks.
   sequence s_start;
      scl_q && scl_s && sda_q && !sda_s;
   endsequence
   sequence s_low_seen;
      low_s && sup_q == SUP_RUN;
   endsequence

   a_start_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_start and wd_q == WD_RUN) |=> wd_cnt_q == '0 && wd_q == WD_RUN)
      else $error("start did not restart watchdog");
   a_wd_bite: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $rose(wd_q == WD_BITE) |=> rst_q && !comm_enable_o)
      else $error("watchdog bite did not assert reset");
   a_bite_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $rose(wd_q == WD_BITE) |-> $past(wd_cnt_q) >= $past(wd_limit) && !$past(wd_off))
      else $error("watchdog bit early or while disabled");
   a_por_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $past(sup_q) == SUP_POR && sup_q == SUP_RUN |-> $past(sup_cnt_q) == CW'(POR_HOLD_CYC - 1))
      else $error("power-on hold released at wrong count");
   a_low_assert: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      s_low_seen |=> sup_q == SUP_LOW && rst_q && (abort_q || $past(rst_q)))
      else $error("low supply did not assert reset and abort");
   a_low_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $past(sup_q) == SUP_LOW && sup_q == SUP_RUN |-> $past(sup_cnt_q) == CW'(LOW_HOLD_CYC - 1)
      && !$past(low_s))
      else $error("low-supply hold released at wrong count");
   a_pin_polarity: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      rst_oe_o == (rst_q != ACTIVE_HIGH) && rst_o == 1'b0)
      else $error("reset pin polarity wrong");
   a_no_write_rst: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cfg_wr_valid_i && rst_q |=> !cfg_store_o && cfg_refused_o)
      else $error("write taken during reset");
   a_write_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cfg_wr_valid_i && lock_s && nv_cfg_i.protect_enable_bit |=> !cfg_store_o)
      else $error("write taken while locked");
   a_reset_or: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      rst_q == (sup_q != SUP_RUN || wd_q == WD_BITE))
      else $error("reset is not the OR of the holds");

endmodule : srw_supervisor

// ==== hw/srw_regs.svh ====
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

// Clock rate of the internal oscillator model, in MHz.
`define SRW_CLK_MHZ         200
// Release delay after power-up, in ms.
`define SRW_POR_HOLD_MS     250
// Release delay after a low-supply event, in ms.
`define SRW_LOW_HOLD_MS     200
// Watchdog timeout choices, in ms (1.4 seconds, 600 ms, 200 ms).
`define SRW_WD_SEL0_MS      1400
`define SRW_WD_SEL1_MS      600
`define SRW_WD_SEL2_MS      200
// Reset hold after a watchdog bite, in ms.
`define SRW_WD_HOLD_MS      250
// Cycle counts derived from the times and the clock rate.
`define SRW_POR_HOLD_CYC    (`SRW_POR_HOLD_MS * `SRW_CLK_MHZ * 1000)
`define SRW_LOW_HOLD_CYC    (`SRW_LOW_HOLD_MS * `SRW_CLK_MHZ * 1000)
`define SRW_WD_SEL0_CYC     (`SRW_WD_SEL0_MS * `SRW_CLK_MHZ * 1000)
`define SRW_WD_SEL1_CYC     (`SRW_WD_SEL1_MS * `SRW_CLK_MHZ * 1000)
`define SRW_WD_SEL2_CYC     (`SRW_WD_SEL2_MS * `SRW_CLK_MHZ * 1000)
`define SRW_WD_HOLD_CYC     (`SRW_WD_HOLD_MS * `SRW_CLK_MHZ * 1000)
// Timeout select encoding; this code switches the watchdog off.
`define SRW_SEL_DISABLED    2'h3
`define SRW_CNT_W           29

`endif

// ==== hw/srw_pkg.sv ====
package srw_pkg;

   // Supply supervision states.
   typedef enum logic [2:0] {
      SUP_POR = 3'h1,
      SUP_LOW = 3'h2,
      SUP_RUN = 3'h4
   } srw_sup_e;

   // Watchdog states.
   typedef enum logic [1:0] {
      WD_RUN  = 2'h1,
      WD_BITE = 2'h2
   } srw_wd_e;

   // Nonvolatile control bits that this block uses.
   typedef struct packed {
      logic protect_enable_bit;
      logic timeout_select_hi;
      logic timeout_select_lo;
   } srw_cfg_s;

endpackage : srw_pkg

// ==== hw/srw_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin inputs.
module srw_sync #(
   parameter int       WIDTH = 1,
   parameter bit [7:0] RST   = 8'h00
) (
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   // Only the second stage of each bit is ever read outside.
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            meta_q <= RST[g];
            sync_q <= RST[g];
         end else begin
            meta_q <= async_i[g];
            sync_q <= meta_q;
         end
      end
      assign sync_o[g] = sync_q;
   end

endmodule : srw_sync

// ==== sim/srw_host_model.sv ====
`timescale 1ns/1ps
// Host side of the two-wire bus; released lines float to the pull-up level.
module srw_host_model (
   output logic scl_o,
   output logic sda_o
);
   // Both lines idle released, so the link clock stands still between frames.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Short frame on a 160 ns link clock; a fake one drops data with the clock low.
   task automatic frame(input bit real_start);
      if (!real_start) begin
         scl_o = 1'b0;
         #40;
      end
      sda_o = 1'b0;
      #80 scl_o = ~scl_o;
      #80 scl_o = 1'b1;
      #80 sda_o = 1'b1;
      // Idle gap, so the falling data edge of a following frame is not lost.
      #80;
   endtask : frame
endmodule : srw_host_model

// ==== sim/srw_supervisor_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the supervisor with the host model on the bus.
module srw_supervisor_tb;
   import srw_pkg::*;
   localparam int POR  = 40;
   localparam int LOW  = 30;
   localparam int HOLD = 25;
   localparam int LIM [4] = '{200, 120, 60, 0};

   logic     clk_i, reset_n_i, supply_low_i, scl, sda, lock, rst_pin, wr_valid;
   srw_cfg_s nv_cfg, wr_data, store_data, d;
   logic     rst_dat, rst_oe, comm_en, abort, store, refused;
   int       fail_count = 0, n_tests = 0, cyc = 0, n_abort = 0, k;
   int       exp_q [$];

   // Clock at 200 MHz.
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Open-drain reset wire with its pull-up.
   assign rst_pin = rst_oe ? rst_dat : 1'b1;

   // A hang is cut short well beyond the expected run length.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end

   // Abort pulses are one cycle long, so every falling edge is looked at.
   always @(negedge clk_i) n_abort += (abort === 1'b1);

   srw_host_model host (.scl_o(scl), .sda_o(sda));

   srw_supervisor #(.POR_HOLD_CYC(POR), .LOW_HOLD_CYC(LOW), .WD_SEL0_CYC(LIM[0]),
      .WD_SEL1_CYC(LIM[1]), .WD_SEL2_CYC(LIM[2]), .WD_HOLD_CYC(HOLD)) dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_low_i(supply_low_i),
      .scl_i(scl), .sda_i(sda), .write_lock_pin_i(lock), .rst_pin_i(rst_pin),
      .nv_cfg_i(nv_cfg), .cfg_wr_valid_i(wr_valid), .cfg_wr_data_i(wr_data),
      .rst_o(rst_dat), .rst_oe_o(rst_oe), .comm_enable_o(comm_en),
      .comm_abort_o(abort), .cfg_store_o(store), .cfg_store_data_o(store_data),
      .cfg_refused_o(refused));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Counts falling edges until the pin enable reaches lvl, giving up at max.
   task automatic wait_oe(input logic lvl, input int max, output int c);
      c = 0;
      while (rst_oe !== lvl && c < max) begin
         @(negedge clk_i);
         c++;
      end
   endtask : wait_oe

   // One write; the model's queue says whether it must be stored or refused.
   task automatic wr(input srw_cfg_s v);
      bit ok;
      ok       = exp_q.pop_front();
      wr_valid = 1'b1;
      wr_data  = v;
      @(negedge clk_i);
      wr_valid = 1'b0;
      // The answer pulse stands only in the cycle after the request edge.
      check({store, refused}, ok ? 2'h2 : 2'h1);
      if (ok) check(store_data, v);
      @(negedge clk_i);
   endtask : wr

   // A shorter timeout may bite at once if the count already passed the new limit; let it settle.
   task automatic set_sel(input logic [1:0] s);
      nv_cfg = {1'b0, s};
      repeat (4) @(negedge clk_i);
      wait_oe(1'b0, 60, k);
   endtask : set_sel

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // Main sequence.
   initial begin
      {reset_n_i, supply_low_i, lock, wr_valid} = 4'h0;
      nv_cfg  = 3'h3;
      wr_data = 3'h0;
      void'($urandom(32'h9dd7));
      repeat (12) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (5) @(negedge clk_i);
      check(comm_en, 1'b0);
      exp_q.push_back(0);
      wr(3'h5);
      wait_oe(1'b0, POR + 20, k);
      check(k + 7 >= POR && k + 7 <= POR + 8, 1);
      check(comm_en, 1'b1);
      check(rst_dat, 1'b0);
      $display("test power_up done");
      for (int i = 0; i < 8; i++) begin
         lock = 1'($urandom);
         nv_cfg.protect_enable_bit = 1'($urandom);
         repeat (3) @(negedge clk_i);
         d = 3'($urandom);
         exp_q.push_back(!(lock && nv_cfg.protect_enable_bit));
         wr(d);
      end
      lock = 1'b0;
      $display("test config_write done");
      for (int s = 0; s < 4; s++) begin
         set_sel(2'(s));
         fork host.frame(1'b1); join_none
         wait_oe(1'b1, 300, k);
         if (s == 3) check(k, 300);
         else begin
            check(k >= LIM[s] && k <= LIM[s] + 8, 1);
            wait_oe(1'b0, 60, k);
            check(k >= HOLD - 1 && k <= HOLD + 2, 1);
         end
      end
      $display("test timeouts done");
      set_sel(2'h1);
      for (int i = 0; i < 6; i++) begin
         host.frame(1'b1);
         check(rst_oe, 1'b0);
      end
      n_abort = 0;
      fork begin host.frame(1'b1); host.frame(1'b0); end join_none
      wait_oe(1'b1, 300, k);
      check(k >= LIM[1] && k <= LIM[1] + 8, 1);
      wait_oe(1'b0, 60, k);
      check(n_abort, 1);
      $display("test keep_alive done");
      nv_cfg  = 3'h3;
      n_abort = 0;
      supply_low_i = 1'b1;
      wait_oe(1'b1, 10, k);
      check(k <= 5, 1);
      repeat (3) @(negedge clk_i);
      check(n_abort, 1);
      check(comm_en, 1'b0);
      exp_q.push_back(0);
      wr(3'h2);
      supply_low_i = 1'b0;
      repeat (15) @(negedge clk_i);
      supply_low_i = 1'b1;
      repeat (3) @(negedge clk_i);
      supply_low_i = 1'b0;
      wait_oe(1'b0, LOW + 20, k);
      check(k >= LOW && k <= LOW + 8, 1);
      $display("test low_supply done");
      nv_cfg    = 3'h2;
      reset_n_i = 1'b0;
      repeat (12) @(negedge clk_i);
      reset_n_i = 1'b1;
      wait_oe(1'b0, POR + 20, k);
      wait_oe(1'b1, 100, k);
      check(k >= LIM[2] && k <= LIM[2] + 8, 1);
      $display("test power_cycle done");
      summarize();
   end
endmodule : srw_supervisor_tb
